// ===== src/wad_regs.vh
`ifndef WAD_REGS_VH
`define WAD_REGS_VH
// Word and field sizes
`define WAD_W          30
`define WAD_BW         15
`define WAD_SHW        6
// Wishbone register byte offsets
`define WAD_OFF_INSTR  8'h00
`define WAD_OFF_OPND   8'h04
`define WAD_OFF_ACC    8'h08
`define WAD_OFF_AUX    8'h0c
`define WAD_OFF_STAT   8'h10
`define WAD_OFF_MEMW   8'h14
`define WAD_OFF_CHO    8'h18
`define WAD_OFF_IDX0   8'h20
`define WAD_OFF_IDXL   8'h3c
// Instruction field positions within the control word
`define WAD_F_OP_HI    14
`define WAD_F_OP_LO    9
`define WAD_F_J_HI     8
`define WAD_F_J_LO     6
`define WAD_F_K_HI     5
`define WAD_F_K_LO     3
`define WAD_F_CH_HI    2
`define WAD_F_CH_LO    0
// Opcodes (octal in the instruction set)
`define WAD_OP_LSQ     6'o05
`define WAD_OP_LSA     6'o06
`define WAD_OP_LSD     6'o07
`define WAD_OP_ENQ     6'o10
`define WAD_OP_ENA     6'o11
`define WAD_OP_ENB     6'o12
`define WAD_OP_EXF     6'o13
`define WAD_OP_STQ     6'o14
`define WAD_OP_STA     6'o15
`define WAD_OP_STB     6'o16
`define WAD_OP_STC     6'o17
`define WAD_OP_ADD     6'o20
`define WAD_OP_SUB     6'o21
`define WAD_OP_MUL     6'o22
`define WAD_OP_DIV     6'o23
`define WAD_OP_RAP     6'o24
`define WAD_OP_RAM     6'o25
`define WAD_OP_ADQ     6'o26
`define WAD_OP_SBQ     6'o27
`define WAD_OP_EYQ     6'o30
`define WAD_OP_EYMQ    6'o31
`define WAD_OP_SAPQ    6'o32
`define WAD_OP_SAMQ    6'o33
`define WAD_OP_RYPQ    6'o34
`define WAD_OP_RYMQ    6'o35
`define WAD_OP_RINC    6'o36
`define WAD_OP_RDEC    6'o37
`define WAD_OP_ELP     6'o40
`define WAD_OP_ALP     6'o41
`define WAD_OP_SLP     6'o42
`define WAD_OP_CMPM    6'o43
`define WAD_OP_RLP     6'o44
`define WAD_OP_RALP    6'o45
`define WAD_OP_RSLP    6'o46
`define WAD_OP_STLP    6'o47
`define WAD_OP_SSET    6'o50
`define WAD_OP_SCPL    6'o51
`define WAD_OP_SCLR    6'o52
`define WAD_OP_SSUB    6'o53
// Operand interpretation values
`define WAD_K_CPL0     3'h0
`define WAD_K_CHAN     3'h3
`define WAD_K_ALT4     3'h4
`define WAD_SHMAX      6'h3b
`define WAD_DIV_STEPS  5'h1e
`endif

// ===== src/wad_idx_mem.v
`include "wad_regs.vh"
// Eight index registers, slot 0 writable like the others, registered read port
module wad_idx_mem (
	// Clock
	input  wire                 clk_i,
	input  wire                 rst_i,
	input  wire                 ce_i,
	// Write
	input  wire                 we_i,
	input  wire [2:0]           wa_i,
	input  wire [`WAD_BW-1:0]   wd_i,
	// Read
	input  wire [2:0]           ra_i,
	output reg  [`WAD_BW-1:0]   rd_o
);
	reg [`WAD_BW-1:0] mem_r [0:7];
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_ent
			always @(posedge clk_i) begin
				if (rst_i)
					mem_r[g] <= {`WAD_BW{1'b0}};
				else if (ce_i && we_i && wa_i == g)
					mem_r[g] <= wd_i;
			end
		end
	endgenerate
	always @(posedge clk_i) begin
		if (rst_i)
			rd_o <= {`WAD_BW{1'b0}};
		else if (ce_i)
			rd_o <= mem_r[ra_i];
	end
endmodule

// ===== src/wad_div.v
`include "wad_regs.vh"
// Sequential restoring divider on magnitudes, one quotient bit per cycle
module wad_div (
	// Clock
	input  wire                   clk_i,
	input  wire                   rst_i,
	input  wire                   ce_i,
	// Request
	input  wire                   start_i,
	input  wire [2*`WAD_W-1:0]    dvd_i,
	input  wire [`WAD_W-1:0]      dvs_i,
	// Result
	output reg                    done_o,
	output reg                    fault_o,
	output reg  [`WAD_W-1:0]      quo_o,
	output reg  [`WAD_W-1:0]      rem_o
);
	reg [2*`WAD_W-1:0] n_r;
	reg [`WAD_W:0]     p_r;
	reg [4:0]          cnt_r;
	reg                busy_r;
	wire [`WAD_W:0]    trial = {p_r[`WAD_W-1:0], n_r[2*`WAD_W-1]} - {1'b0, dvs_i};
	always @(posedge clk_i) begin
		if (rst_i) begin
			n_r <= {2*`WAD_W{1'b0}};
			p_r <= {(`WAD_W+1){1'b0}};
			cnt_r <= 5'h0;
			busy_r <= 1'b0;
			done_o <= 1'b0;
			fault_o <= 1'b0;
			quo_o <= {`WAD_W{1'b0}};
			rem_o <= {`WAD_W{1'b0}};
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (start_i && !busy_r) begin
				// Quotient must fit in one word: high half below divisor
				if (dvs_i == {`WAD_W{1'b0}} || dvd_i[2*`WAD_W-1:`WAD_W] >= dvs_i) begin
					fault_o <= 1'b1;
					done_o <= 1'b1;
				end else begin
					fault_o <= 1'b0;
					p_r <= {1'b0, dvd_i[2*`WAD_W-1:`WAD_W]};
					n_r <= {dvd_i[`WAD_W-1:0], {`WAD_W{1'b0}}};
					cnt_r <= 5'h0;
					busy_r <= 1'b1;
				end
			end else if (busy_r) begin
				if (!trial[`WAD_W]) begin
					p_r <= trial;
					quo_o <= {quo_o[`WAD_W-2:0], 1'b1};
				end else begin
					p_r <= {p_r[`WAD_W-1:0], n_r[2*`WAD_W-1]};
					quo_o <= {quo_o[`WAD_W-2:0], 1'b0};
				end
				n_r <= {n_r[2*`WAD_W-2:0], 1'b0};
				cnt_r <= cnt_r + 5'h1;
				if (cnt_r == `WAD_DIV_STEPS - 5'h1) begin
					busy_r <= 1'b0;
					done_o <= 1'b1;
					rem_o <= !trial[`WAD_W] ? trial[`WAD_W-1:0]
						: {p_r[`WAD_W-2:0], n_r[2*`WAD_W-1]};
				end
			end
		end
	end
endmodule

// ===== src/wad_core.v
`include "wad_regs.vh"
//////////////////////////////////////////////////////////////////////////////
// What this block does
// [RULE1] Double left shift rotates accumulator and auxiliary as one 60-bit ring.
// [RULE2] Shift count is operand bits 5..0 only; upper bits ignored.
// [RULE3] Software never asks for shifts above 59 places.
// [RULE4] Load opcodes 10/11 clear then load auxiliary or accumulator.
// [RULE5] Index load writes operand low 15 bits into register chosen by j.
// [RULE6] External function on channel 0/1 skips if remote input buffer active.
// [RULE7] External function elsewhere sends operand on channel; k must be 3.
// [RULE8] Store auxiliary: k=0 stores complement, k=4 writes accumulator.
// [RULE9] Store accumulator: k=4 stores complement, k=0 writes auxiliary.
// [RULE10] Store index writes 15-bit register zero-extended to 30 bits.
// [RULE11] Store channel writes input word then acknowledges; k must be 3.
// [RULE12] Multiply puts double-length auxiliary times operand into the pair.
// [RULE13] Multiply j=4 skips when upper product half is zero.
// [RULE14] Divide leaves quotient in auxiliary, remainder with quotient sign.
// [RULE15] Divide fault skips with j=3; with j=2 skip means correct.
// [RULE16] Auxiliary add/subtract changes auxiliary only.
// [RULE17] Auxiliary add/subtract use the same eight skip tests as other instructions.
// [RULE18] Reverse subtract load gives operand minus auxiliary in accumulator.
// [RULE19] Increment/decrement replace combine one with memory, write back.
// [RULE20] Store sum/difference update accumulator then store per k.
// [RULE21] Logical product load/replace: j=2 skip even parity, j=3 odd.
// [RULE22] Masked compare tests accumulator minus masked operand, no change.
// [RULE23] Selective set/complement/clear touch only operand-one bits.
// [RULE24] Selective substitute copies operand bits where auxiliary is one.
// [RULE25] Words are 30-bit ones complement, sign in the top bit.
module wad_core (
	// Clock and reset
	input  wire                clk_i,
	input  wire                rst_i,
	input  wire                ce_i,
	// Wishbone slave
	input  wire                cyc_i,
	input  wire                stb_i,
	input  wire                we_i,
	input  wire [7:0]          adr_i,
	input  wire [3:0]          sel_i,
	input  wire [31:0]         dat_i,
	output reg  [31:0]         dat_o,
	output reg                 ack_o,
	// Channel pins
	input  wire [1:0]          remote_in_act_i,
	input  wire [`WAD_W-1:0]   chan_in_i,
	output reg  [`WAD_W-1:0]   chan_out_o,
	output reg  [2:0]          chan_sel_o,
	output reg                 ext_func_o,
	output reg                 in_ack_o
);
	localparam W = `WAD_W;
	localparam [W-1:0] ZERO = {W{1'b0}};
	localparam [W-1:0] ONES = {W{1'b1}};
	localparam [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};
	// States, one-hot
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_EXEC = 4'h2;
	localparam [3:0] ST_DIV  = 4'h4;
	localparam [3:0] ST_BRD  = 4'h8;

	//////////////////////////////////////////////////////////////////////////
	// Ones-complement helpers
	function [W-1:0] oc_add;
		input [W-1:0] a;
		input [W-1:0] b;
		reg   [W:0]   s;
		begin
			s = {1'b0, a} + {1'b0, b};
			oc_add = s[W-1:0] + {{(W-1){1'b0}}, s[W]}; // [RULE25]
		end
	endfunction
	function [W-1:0] oc_abs;
		input [W-1:0] a;
		begin
			oc_abs = a[W-1] ? ~a : a;
		end
	endfunction
	function oc_zero;
		input [W-1:0] a;
		begin
			oc_zero = (a == ZERO) || (a == ONES);
		end
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Registers
	reg [3:0]   st_r;
	reg [15:0]  instr_r;
	reg [W-1:0] opnd_r;
	reg [W-1:0] acc_r;
	reg [W-1:0] aux_r;
	reg [W-1:0] memw_r;
	reg         memw_v_r;
	reg         skip_r;
	reg         fault_r;
	reg         go_r;
	reg [1:0]   ria_m_r;
	reg [1:0]   ria_r;
	reg [W-1:0] cin_m_r;
	reg [W-1:0] cin_r;
	reg         xw_r;
	reg [2:0]   xa_r;
	reg [`WAD_BW-1:0] xd_r;
	reg         dstart_r;
	reg         dsign_r;
	wire [5:0] op = instr_r[`WAD_F_OP_HI:`WAD_F_OP_LO];
	wire [2:0] j  = instr_r[`WAD_F_J_HI:`WAD_F_J_LO];
	wire [2:0] k  = instr_r[`WAD_F_K_HI:`WAD_F_K_LO];
	wire [2:0] ch = instr_r[`WAD_F_CH_HI:`WAD_F_CH_LO];
	wire [`WAD_BW-1:0] idx_rd;
	wire        d_done;
	wire        d_fault;
	wire [W-1:0] d_quo;
	wire [W-1:0] d_rem;

	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always @(posedge clk_i) begin
		if (rst_i) begin
			ria_m_r <= 2'h0;
			ria_r <= 2'h0;
			cin_m_r <= ZERO;
			cin_r <= ZERO;
		end else if (ce_i) begin
			ria_m_r <= remote_in_act_i;
			ria_r <= ria_m_r;
			cin_m_r <= chan_in_i;
			cin_r <= cin_m_r;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Index registers; read port is j while an instruction waits, else the bus index
	wad_idx_mem u_idx (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.we_i  (xw_r),
		.wa_i  (xa_r),
		.wd_i  (xd_r),
		.ra_i  (go_r ? j : adr_i[4:2]),
		.rd_o  (idx_rd)
	);

	// Divider works on magnitudes; signs fixed up on completion
	wire dvd_neg = acc_r[W-1];
	wire [2*W-1:0] dvd_mag = dvd_neg ? ~{acc_r, aux_r} : {acc_r, aux_r};
	wad_div u_div (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.start_i (dstart_r),
		.dvd_i   (dvd_mag),
		.dvs_i   (oc_abs(opnd_r)),
		.done_o  (d_done),
		.fault_o (d_fault),
		.quo_o   (d_quo),
		.rem_o   (d_rem)
	);

	//////////////////////////////////////////////////////////////////////////
	// Datapath
	wire [W-1:0] lp    = opnd_r & aux_r;
	wire [W-1:0] a_add = oc_add(acc_r, opnd_r);
	wire [W-1:0] a_sub = oc_add(acc_r, ~opnd_r);
	wire [W-1:0] q_add = oc_add(aux_r, opnd_r);               // [RULE16]
	wire [W-1:0] q_sub = oc_add(aux_r, ~opnd_r);              // [RULE16]
	wire [5:0]   shc   = opnd_r[`WAD_SHW-1:0];                // [RULE2]
	wire [2*W-1:0] pair = {acc_r, aux_r};
	wire [4*W-1:0] dbl  = {pair, pair} << shc;                // [RULE1]
	wire [2*W-1:0] rot60 = dbl[4*W-1:2*W];
	wire [2*W-1:0] wq   = {aux_r, aux_r} << shc;
	wire [2*W-1:0] wa   = {acc_r, acc_r} << shc;
	// Multiply on magnitudes, ones-complement sign applied to both halves
	wire         m_neg = aux_r[W-1] ^ opnd_r[W-1];
	wire [2*W-1:0] m_mag = oc_abs(aux_r) * oc_abs(opnd_r);   // [RULE12]
	wire [2*W-1:0] m_res = m_neg ? ~m_mag : m_mag;

	reg [W-1:0] acc_nxt;
	reg [W-1:0] aux_nxt;
	reg [W-1:0] memw_nxt;
	reg         memw_v_nxt;
	reg         skip_nxt;
	reg         std_skip;
	reg         lp_sel;

	// Store path steered by k for the accumulator-store family
	task put_acc;
		input [W-1:0] v;
		begin
			if (k == `WAD_K_ALT4)
				memw_nxt = ~v;                                    // [RULE9]
			else if (k == `WAD_K_CPL0)
				aux_nxt = v;                                      // [RULE9]
			else
				memw_nxt = v;
			memw_v_nxt = (k != `WAD_K_CPL0);
		end
	endtask

	always @* begin
		acc_nxt = acc_r;
		aux_nxt = aux_r;
		memw_nxt = memw_r;
		memw_v_nxt = 1'b0;
		lp_sel = 1'b0;
		case (op)
		`WAD_OP_LSQ: aux_nxt = wq[2*W-1:W];
		`WAD_OP_LSA: acc_nxt = wa[2*W-1:W];
		`WAD_OP_LSD: begin
			acc_nxt = rot60[2*W-1:W];                           // [RULE1]
			aux_nxt = rot60[W-1:0];
		end
		`WAD_OP_ENQ: aux_nxt = opnd_r;                          // [RULE4]
		`WAD_OP_ENA: acc_nxt = opnd_r;                          // [RULE4]
		`WAD_OP_STQ: begin
			if (k == `WAD_K_ALT4)
				acc_nxt = aux_r;                                  // [RULE8]
			else begin
				memw_nxt = (k == `WAD_K_CPL0) ? ~aux_r : aux_r;   // [RULE8]
				memw_v_nxt = 1'b1;
			end
		end
		`WAD_OP_STA: put_acc(acc_r);
		`WAD_OP_STB: begin
			memw_nxt = {{(W-`WAD_BW){1'b0}}, idx_rd};           // [RULE10]
			memw_v_nxt = 1'b1;
		end
		`WAD_OP_STC: begin
			memw_nxt = cin_r;                                   // [RULE11]
			memw_v_nxt = 1'b1;
		end
		`WAD_OP_ADD: acc_nxt = a_add;
		`WAD_OP_SUB: acc_nxt = a_sub;
		`WAD_OP_MUL: begin
			acc_nxt = m_res[2*W-1:W];                           // [RULE12]
			aux_nxt = m_res[W-1:0];
		end
		`WAD_OP_RAP: begin
			acc_nxt = a_add;
			memw_nxt = a_add;
			memw_v_nxt = 1'b1;
		end
		`WAD_OP_RAM: begin
			acc_nxt = a_sub;
			memw_nxt = a_sub;
			memw_v_nxt = 1'b1;
		end
		`WAD_OP_ADQ: aux_nxt = q_add;                           // [RULE16]
		`WAD_OP_SBQ: aux_nxt = q_sub;                           // [RULE16]
		`WAD_OP_EYQ: acc_nxt = q_add;
		`WAD_OP_EYMQ: acc_nxt = ~q_sub;                         // [RULE18]
		`WAD_OP_SAPQ: begin
			acc_nxt = oc_add(acc_r, aux_r);                     // [RULE20]
			put_acc(oc_add(acc_r, aux_r));
		end
		`WAD_OP_SAMQ: begin
			acc_nxt = oc_add(acc_r, ~aux_r);                    // [RULE20]
			put_acc(oc_add(acc_r, ~aux_r));
		end
		`WAD_OP_RYPQ: begin
			acc_nxt = q_add;
			memw_nxt = q_add;
			memw_v_nxt = 1'b1;
		end
		`WAD_OP_RYMQ: begin
			acc_nxt = ~q_sub;
			memw_nxt = ~q_sub;
			memw_v_nxt = 1'b1;
		end
		`WAD_OP_RINC: begin
			acc_nxt = oc_add(ONE, opnd_r);                      // [RULE19]
			memw_nxt = oc_add(ONE, opnd_r);
			memw_v_nxt = 1'b1;
		end
		`WAD_OP_RDEC: begin
			acc_nxt = ~oc_add(ONE, ~opnd_r);                    // [RULE19]
			memw_nxt = ~oc_add(ONE, ~opnd_r);
			memw_v_nxt = 1'b1;
		end
		`WAD_OP_ELP: begin
			acc_nxt = lp;
			lp_sel = 1'b1;
		end
		`WAD_OP_ALP: acc_nxt = oc_add(acc_r, lp);
		`WAD_OP_SLP: acc_nxt = oc_add(acc_r, ~lp);
		`WAD_OP_CMPM: acc_nxt = acc_r;                          // [RULE22]
		`WAD_OP_RLP: begin
			acc_nxt = lp;
			lp_sel = 1'b1;
			memw_nxt = lp;
			memw_v_nxt = 1'b1;
		end
		`WAD_OP_RALP: begin
			acc_nxt = oc_add(acc_r, lp);
			memw_nxt = oc_add(acc_r, lp);
			memw_v_nxt = 1'b1;
		end
		`WAD_OP_RSLP: begin
			acc_nxt = oc_add(acc_r, ~lp);
			memw_nxt = oc_add(acc_r, ~lp);
			memw_v_nxt = 1'b1;
		end
		`WAD_OP_STLP: put_acc(acc_r & aux_r);
		`WAD_OP_SSET: acc_nxt = acc_r | opnd_r;                 // [RULE23]
		`WAD_OP_SCPL: acc_nxt = acc_r ^ opnd_r;                 // [RULE23]
		`WAD_OP_SCLR: acc_nxt = acc_r & ~opnd_r;                // [RULE23]
		`WAD_OP_SSUB: acc_nxt = (acc_r & ~aux_r) | (opnd_r & aux_r); // [RULE24]
		default: acc_nxt = acc_r;
		endcase
	end

	// Skip evaluation on the final register values
	wire [W-1:0] cmp_v = oc_add(acc_r, ~lp);
	always @* begin
		case (j)
		3'h0: std_skip = 1'b0;
		3'h1: std_skip = 1'b1;
		3'h2: std_skip = !acc_nxt[W-1];
		3'h3: std_skip = acc_nxt[W-1];
		3'h4: std_skip = oc_zero(aux_nxt);                      // [RULE17]
		3'h5: std_skip = !oc_zero(aux_nxt);
		3'h6: std_skip = !aux_nxt[W-1];
		default: std_skip = aux_nxt[W-1];
		endcase
		skip_nxt = std_skip;
		if (op == `WAD_OP_CMPM)
			skip_nxt = (j == 3'h0) ? 1'b0 : (j == 3'h1) ? 1'b1 :
				(j == 3'h2) ? !cmp_v[W-1] : (j == 3'h3) ? cmp_v[W-1] :
				(j == 3'h4) ? oc_zero(cmp_v) : (j == 3'h5) ? !oc_zero(cmp_v) :
				(j == 3'h6) ? !cmp_v[W-1] : cmp_v[W-1];            // [RULE22]
		else if (op == `WAD_OP_MUL && j == 3'h4)
			skip_nxt = oc_zero(m_res[2*W-1:W]);                 // [RULE13]
		else if (lp_sel && (j == 3'h2 || j == 3'h3))
			skip_nxt = (^acc_nxt) == (j == 3'h3);               // [RULE21]
		else if (op == `WAD_OP_ENB || op == `WAD_OP_STB)
			skip_nxt = 1'b0;                                    // [RULE5]
		else if (op == `WAD_OP_EXF || op == `WAD_OP_STC)
			skip_nxt = (op == `WAD_OP_EXF && ch <= 3'h1) ? ria_r[ch[0]] : 1'b0; // [RULE6]
	end

	//////////////////////////////////////////////////////////////////////////
	// Sequencer and bus slave
	wire        wb_req = cyc_i && stb_i && !ack_o;
	wire        wr_all = we_i && (sel_i == 4'hf);
	wire [2:0]  bus_idx = adr_i[4:2];
	always @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= ST_IDLE;
			instr_r <= 16'h0;
			opnd_r <= ZERO;
			acc_r <= ZERO;
			aux_r <= ZERO;
			memw_r <= ZERO;
			memw_v_r <= 1'b0;
			skip_r <= 1'b0;
			fault_r <= 1'b0;
			go_r <= 1'b0;
			xw_r <= 1'b0;
			xa_r <= 3'h0;
			xd_r <= {`WAD_BW{1'b0}};
			dstart_r <= 1'b0;
			dsign_r <= 1'b0;
			dat_o <= 32'h0;
			ack_o <= 1'b0;
			chan_out_o <= ZERO;
			chan_sel_o <= 3'h0;
			ext_func_o <= 1'b0;
			in_ack_o <= 1'b0;
		end else if (ce_i) begin
			ack_o <= 1'b0;
			xw_r <= 1'b0;
			dstart_r <= 1'b0;
			ext_func_o <= 1'b0;
			in_ack_o <= 1'b0;
			go_r <= 1'b0;
			case (st_r)
			ST_IDLE: begin
				if (go_r)
					st_r <= ST_EXEC;
				else if (wb_req) begin
					ack_o <= 1'b1;
					dat_o <= 32'h0;
					if (wr_all) begin
						case (adr_i)
						`WAD_OFF_INSTR: begin
							instr_r <= dat_i[15:0];
							go_r <= 1'b1;
						end
						`WAD_OFF_OPND: opnd_r <= dat_i[W-1:0];
						`WAD_OFF_ACC:  acc_r <= dat_i[W-1:0];
						`WAD_OFF_AUX:  aux_r <= dat_i[W-1:0];
						default: begin
							if (adr_i >= `WAD_OFF_IDX0 && adr_i <= `WAD_OFF_IDXL) begin
								xw_r <= 1'b1;
								xa_r <= bus_idx;
								xd_r <= dat_i[`WAD_BW-1:0];
							end
						end
						endcase
					end else if (!we_i) begin
						case (adr_i)
						`WAD_OFF_INSTR: dat_o <= {16'h0, instr_r};
						`WAD_OFF_OPND:  dat_o <= {2'h0, opnd_r};
						`WAD_OFF_ACC:   dat_o <= {2'h0, acc_r};
						`WAD_OFF_AUX:   dat_o <= {2'h0, aux_r};
						`WAD_OFF_STAT:  dat_o <= {28'h0, fault_r, memw_v_r, skip_r, 1'b0};
						`WAD_OFF_MEMW:  dat_o <= {2'h0, memw_r};
						default: begin
							if (adr_i >= `WAD_OFF_IDX0 && adr_i <= `WAD_OFF_IDXL) begin
								st_r <= ST_BRD;
								ack_o <= 1'b0;
							end
						end
						endcase
					end
				end
			end
			ST_BRD: begin
				// Index memory read port is registered: answer one cycle later
				dat_o <= {17'h0, idx_rd};
				ack_o <= 1'b1;
				st_r <= ST_IDLE;
			end
			ST_EXEC: begin
				acc_r <= acc_nxt;
				aux_r <= aux_nxt;
				memw_r <= memw_nxt;
				memw_v_r <= memw_v_nxt;
				skip_r <= skip_nxt;
				fault_r <= 1'b0;
				st_r <= ST_IDLE;
				if (op == `WAD_OP_ENB) begin
					xw_r <= 1'b1;                                   // [RULE5]
					xa_r <= j;
					xd_r <= opnd_r[`WAD_BW-1:0];
				end
				if (op == `WAD_OP_EXF && ch > 3'h1 && k == `WAD_K_CHAN) begin
					ext_func_o <= 1'b1;                             // [RULE7]
					chan_out_o <= opnd_r;
					chan_sel_o <= ch;
				end
				if (op == `WAD_OP_STC && k == `WAD_K_CHAN) begin
					in_ack_o <= 1'b1;                               // [RULE11]
					chan_sel_o <= ch;
				end
				if (op == `WAD_OP_DIV) begin
					dstart_r <= 1'b1;
					dsign_r <= acc_r[W-1] ^ opnd_r[W-1];
					st_r <= ST_DIV;
				end
			end
			ST_DIV: begin
				if (d_done) begin
					fault_r <= d_fault;
					if (!d_fault) begin
						aux_r <= dsign_r ? ~d_quo : d_quo;          // [RULE14]
						acc_r <= dsign_r ? ~d_rem : d_rem;          // [RULE14]
					end
					skip_r <= (j == 3'h3) ? d_fault :               // [RULE15]
						(j == 3'h2) ? !d_fault : (j == 3'h1);
					st_r <= ST_IDLE;
				end
			end
			default: st_r <= ST_IDLE;
			endcase
		end
	end
	// Shift counts above 59 are not checked here [RULE3]
endmodule

// ===== tb/wad_core_assertions.sv
`include "wad_regs.vh"
module wad_core_assertions (
	// Clock and reset
	input wire logic              clk_i,
	input wire logic              rst_i,
	// Bus
	input wire logic              cyc_i,
	input wire logic              stb_i,
	input wire logic              ack_o,
	// Channel
	input wire logic              ext_func_o,
	input wire logic              in_ack_o,
	input wire logic [2:0]        chan_sel_o,
	input wire logic [`WAD_W-1:0] chan_out_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	//////////////////////////////////////////////////////////////////////////////
	a_ack_single:
		assert property (ack_o |=> !ack_o) else $error("ack held too long");
	a_ack_cause:
		assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
	// Divide is the longest wait, well inside this bound
	a_ack_bound:
		assert property ($rose(stb_i) |-> ##[1:80] ack_o) else $error("ack never came");
	a_ext_pulse:
		assert property (ext_func_o |=> !ext_func_o) else $error("function pulse too long");
	a_ext_far_chan:
		assert property (ext_func_o |-> chan_sel_o > 3'h1) else $error("function on channel 0/1");
	a_out_only_fn:
		assert property ($changed(chan_out_o) |-> ext_func_o) else $error("word moved alone");
	a_in_ack_pulse:
		assert property (in_ack_o |=> !in_ack_o) else $error("input ack too long");
	a_fn_ack_apart:
		assert property (!(ext_func_o && in_ack_o)) else $error("function and ack together");
endmodule
bind wad_core wad_core_assertions i_wad_core_assertions (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .ext_func_o(ext_func_o),
	.in_ack_o(in_ack_o), .chan_sel_o(chan_sel_o), .chan_out_o(chan_out_o));

// ===== tb/wad_chan_model.sv
module wad_chan_model (
	// Clock
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Bench wishes
	input  wire logic [1:0]  busy_i,
	input  wire logic [29:0] word_i,
	// Device side
	input  wire logic        ext_func_i,
	input  wire logic        in_ack_i,
	input  wire logic [29:0] chan_out_i,
	output logic      [1:0]  remote_in_act_o,
	output logic      [29:0] chan_in_o,
	// Observed
	output logic      [29:0] fn_word_o,
	output logic      [7:0]  fn_cnt_o,
	output logic      [7:0]  ack_cnt_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic taken = 1'b0;
	assign remote_in_act_o = busy_i;
	// A consumed word is complemented, so stale data cannot pass as fresh
	assign chan_in_o = taken ? ~word_i : word_i;
	always @(posedge clk_i) begin
		if (rst_i) begin
			taken <= 1'b0;
			fn_cnt_o <= 8'h00;
			ack_cnt_o <= 8'h00;
			fn_word_o <= 30'h0;
		end else begin
			if (ext_func_i) begin
				fn_cnt_o <= fn_cnt_o + 8'h01;
				fn_word_o <= chan_out_i;
			end
			if (in_ack_i) begin
				ack_cnt_o <= ack_cnt_o + 8'h01;
				taken <= 1'b1;
			end
		end
	end
endmodule

// ===== tb/tb_top.sv
`include "wad_regs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [15:0] i;
		logic [29:0] y, a, q, ea, eq, em;
		logic [2:0]  s;
	} wad_row_t;
	localparam logic [7:0] AUX_SKIP = 8'h6a;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00, fn_cnt, ack_cnt;
	logic [3:0]  sel = 4'hf;
	logic [31:0] dw = 32'h0, dat_o, rd;
	logic        ack_o, ext_func_o, in_ack_o;
	logic [1:0]  act;
	logic [29:0] chan_in, chan_out_o, fn_word;
	logic [2:0]  chan_sel_o;
	int          err_total = 0, check_count = 0, cyc_cnt = 0;
	wad_row_t    rw [22];
	always #5 clk_i = ~clk_i;
	wad_core i_wad_core (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dw), .dat_o(dat_o), .ack_o(ack_o),
		.remote_in_act_i(act), .chan_in_i(chan_in), .chan_out_o(chan_out_o),
		.chan_sel_o(chan_sel_o), .ext_func_o(ext_func_o), .in_ack_o(in_ack_o));
	wad_chan_model i_wad_chan_model (.clk_i(clk_i), .rst_i(rst_i), .busy_i(2'h1),
		.word_i(30'h1abcdef), .ext_func_i(ext_func_o), .in_ack_i(in_ack_o),
		.chan_out_i(chan_out_o), .remote_in_act_o(act), .chan_in_o(chan_in),
		.fn_word_o(fn_word), .fn_cnt_o(fn_cnt), .ack_cnt_o(ack_cnt));
	//////////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [29:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= {2'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 30'h0);
		chk(rd, exp);
	endtask
	task automatic run(input wad_row_t r);
		wb(1'b1, `WAD_OFF_ACC, r.a);
		wb(1'b1, `WAD_OFF_AUX, r.q);
		wb(1'b1, `WAD_OFF_OPND, r.y);
		wb(1'b1, `WAD_OFF_INSTR, {14'h0, r.i});
		rdc(`WAD_OFF_ACC, {2'h0, r.ea});
		rdc(`WAD_OFF_AUX, {2'h0, r.eq});
		wb(1'b0, `WAD_OFF_STAT, 30'h0);
		chk({29'h0, rd[3:1]}, {29'h0, r.s});
		if (r.s[1])
			rdc(`WAD_OFF_MEMW, {2'h0, r.em});
	endtask
	// Hang guard, far above the fewer than a thousand cycles the run needs
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			summarize();
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		rw = '{
			'{16'o07000,30'h3fffffc2,30'h20000001,30'h3,30'h4,30'he,30'h0,3'h0},
			'{16'o10000,30'h12345678,30'h5,30'h9,30'h5,30'h12345678,30'h0,3'h0},
			'{16'o14000,30'h0,30'h1,30'hf0f,30'h1,30'hf0f,30'h3ffff0f0,3'h2},
			'{16'o15000,30'h0,30'hf0f,30'h1,30'hf0f,30'hf0f,30'h0,3'h0},
			'{16'o27700,30'h5,30'h9,30'h2,30'h9,30'h3ffffffc,30'h0,3'h1},
			'{16'o31000,30'h9,30'h1,30'h5,30'h4,30'h5,30'h0,3'h0},
			'{16'o37000,30'h7,30'h0,30'h0,30'h6,30'h0,30'h6,3'h2},
			'{16'o33030,30'h0,30'h4,30'h3,30'h1,30'h3,30'h1,3'h2},
			'{16'o44200,30'h3,30'h0,30'hf,30'h3,30'hf,30'h3,3'h3},
			'{16'o40300,30'h7,30'h0,30'hf,30'h7,30'hf,30'h0,3'h1},
			'{16'o43300,30'h7,30'h5,30'hff,30'h5,30'hff,30'h0,3'h1},
			'{16'o52000,30'h30,30'hf0,30'h0,30'hc0,30'h0,30'h0,3'h0},
			'{16'o53000,30'h5,30'hf0,30'hf,30'hf5,30'hf,30'h0,3'h0},
			'{16'o22400,30'h5,30'h7,30'h3,30'h0,30'hf,30'h0,3'h1},
			'{16'o23000,30'h3ffffffa,30'h0,30'h11,30'h3ffffffd,30'h3ffffffc,30'h0,3'h0},
			'{16'o23300,30'h0,30'h0,30'h11,30'h0,30'h11,30'h0,3'h5},
			'{16'o23200,30'h5,30'h0,30'h11,30'h2,30'h3,30'h0,3'h1},
			'{16'o12200,30'h3fff1234,30'h0,30'h0,30'h0,30'h0,30'h0,3'h0},
			'{16'o16200,30'h0,30'h0,30'h0,30'h0,30'h0,30'h1234,3'h2},
			'{16'o15040,30'h0,30'hf0f,30'h1,30'hf0f,30'h1,30'h3ffff0f0,3'h2},
			'{16'o14040,30'h0,30'h1,30'hf0f,30'hf0f,30'hf0f,30'h0,3'h0},
			'{16'o36000,30'h7,30'h0,30'h0,30'h8,30'h0,30'h8,3'h2}
		};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rw[n])
			run(rw[n]);
		$display("done: table");
		for (int j = 0; j < 8; j++)
			run('{{7'o26, j[2:0], 6'o0}, 30'h1, 30'h3ffffff0, 30'h1, 30'h3ffffff0, 30'h2,
				30'h0, {2'h0, AUX_SKIP[j]}});
		$display("done: aux skip codes");
		run('{16'o13030,30'h0,30'h0,30'h0,30'h0,30'h0,30'h0,3'h1});
		run('{16'o13031,30'h0,30'h0,30'h0,30'h0,30'h0,30'h0,3'h0});
		run('{16'o13035,30'h2aaaa,30'h5,30'h9,30'h5,30'h9,30'h0,3'h0});
		chk({24'h0, fn_cnt}, 32'h1);
		chk({2'h0, fn_word}, 32'h2aaaa);
		run('{16'o17034,30'h0,30'h5,30'h9,30'h5,30'h9,30'h1abcdef,3'h2});
		chk({24'h0, ack_cnt}, 32'h1);
		$display("done: channels");
		sel <= 4'h3;
		wb(1'b1, `WAD_OFF_ACC, 30'h7);
		sel <= 4'hf;
		rdc(`WAD_OFF_ACC, 32'h5);
		rdc(8'h1c, 32'h0);
		rdc(8'h28, 32'h1234);
		$display("done: bus refusals");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({2'h0, chan_out_o}, 32'h0);
		$display("done: second reset");
		summarize();
	end
endmodule
